// >>> hdl/irb_pkg.sv
// constants and types shared by the indirect register access bridge
package irb_pkg;

   // ---------------------------------------------------------------
   // register bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;

   // ---------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_ANA_CTRL = 8'h40;
   localparam logic [7:0] IDX_ANA_OFFSET = 8'h41;
   localparam logic [7:0] IDX_ANA_DATA = 8'h42;
   localparam logic [7:0] IDX_IB_CTRL = 8'h48;
   localparam logic [7:0] IDX_IB_ADDR_LOW = 8'h49;
   localparam logic [7:0] IDX_IB_ADDR_HIGH = 8'h4a;
   localparam logic [7:0] IDX_IB_DATA0 = 8'h4b;
   localparam logic [7:0] IDX_IB_DATA1 = 8'h4c;
   localparam logic [7:0] IDX_IB_DATA2 = 8'h4d;
   localparam logic [7:0] IDX_IB_DATA3 = 8'h4e;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int ANA_DIR_BIT = 0;
   localparam int ANA_STEP_BIT = 1;
   localparam int ANA_SEL_LSB = 2;
   localparam int ANA_SEL_MSB = 4;
   localparam int IB_EN_BIT = 0;
   localparam int IB_RD_BIT = 1;
   localparam int IB_STEP_BIT = 2;
   localparam int IB_SEL_LSB = 3;
   localparam int IB_SEL_MSB = 4;

   // ---------------------------------------------------------------
   // encodings, steps and reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] ANA_SEL_NONE = 3'h0;
   localparam logic [2:0] ANA_SEL_RX = 3'h4;
   localparam logic [2:0] ANA_SEL_TX = 3'h5;
   localparam logic [1:0] IB_TGT_RX = 2'h0;
   localparam logic [1:0] IB_TGT_EDID = 2'h1;
   localparam logic [1:0] IB_TGT_CFG = 2'h2;
   localparam logic [1:0] IB_TGT_DIE = 2'h3;
   localparam logic [7:0] ANA_STEP = 8'h01;
   localparam logic [15:0] IB_STEP_WORD = 16'h0004;
   localparam logic [15:0] IB_STEP_BYTE = 16'h0001;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_SEL3 = 3'h0;
   localparam logic [1:0] RST_SEL2 = 2'h0;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum {IRB_IDLE, IRB_SETUP, IRB_ACCESS} irb_bus_state_t;

endpackage

// >>> hdl/irb_req_if.sv
// request carrier between the bridge core and its internal bus engine
`timescale 1ns/10ps
interface irb_req_if;
   logic start;
   logic write;
   logic [1:0] target;
   logic [15:0] addr;
   logic [31:0] wdata;
   logic done;
   logic [31:0] rdata;

   modport ctrl (output start, write, target, addr, wdata,
                 input done, rdata);
   modport eng (input start, write, target, addr, wdata,
                output done, rdata);
endinterface

// >>> hdl/irb_apb_master.sv
// internal bus engine: one apb transfer per start pulse
`timescale 1ns/10ps
module irb_apb_master
   import irb_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   irb_req_if.eng req,
   output logic ibPsel,
   output logic ibPenable,
   output logic ibPwrite,
   output logic [15:0] ibPaddr,
   output logic [31:0] ibPwdata,
   output logic [1:0] ibTarget,
   input wire logic [31:0] ibPrdata,
   input wire logic ibPready
);

   irb_bus_state_t state;
   irb_bus_state_t next_state;

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         IRB_IDLE: if (req.start) next_state = IRB_SETUP;
         IRB_SETUP: next_state = IRB_ACCESS;
         IRB_ACCESS: if (ibPready) next_state = IRB_IDLE;
         default: next_state = IRB_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= IRB_IDLE;
         ibPsel <= 1'b0;
         ibPenable <= 1'b0;
      end else begin
         state <= next_state;
         ibPsel <= (next_state != IRB_IDLE);
         ibPenable <= (next_state == IRB_ACCESS);
      end
   end

   // request held stable from setup to the ready edge
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ibPwrite <= 1'b0;
         ibPaddr <= 16'h0000;
         ibPwdata <= RST_WORD;
         ibTarget <= RST_SEL2;
      end else if (state == IRB_IDLE && req.start) begin
         ibPwrite <= req.write;
         ibPaddr <= req.addr;
         ibPwdata <= req.wdata;
         ibTarget <= req.target;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         req.done <= 1'b0;
         req.rdata <= RST_WORD;
      end else begin
         req.done <= (state == IRB_ACCESS) && ibPready;
         if (state == IRB_ACCESS && ibPready && !ibPwrite) begin
            req.rdata <= ibPrdata;
         end
      end
   end

endmodule

// >>> hdl/irb_bridge.sv
// indirect register access bridge: apb register file, analog and bus paths
//
// Function
// - analog select 000 is no target, 100 the receiver, 101 the link tx.
// - with analog autostep set the offset grows by one per completed access.
// - analog direction 0 means indirect write, 1 means indirect read.
// - the 8-bit analog offset register addresses every analog access.
// - writing the analog data register writes that byte to the target.
// - reading the analog data register returns the target register value.
// - bus target 00 receiver, 01 edid sram, 10 config (ro), 11 die id (ro).
// - bus autostep adds 4 for the receiver target and 1 for the others.
// - writing 1 to read-start reads the bus word into the four data bytes.
// - read-start clears itself when the read data is in place.
// - bus transfers only happen while the enable bit is 1.
// - bus address is the high byte over the low byte.
// - data byte 0 is the least significant, byte 1 the next.
// - data byte 2 is next and byte 3 the most significant.
`timescale 1ns/10ps
module irb_bridge
   import irb_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic anaReq,
   output logic anaWrite,
   output logic anaSelRx,
   output logic anaSelTx,
   output logic [7:0] anaOffset,
   output logic [7:0] anaWdata,
   input wire logic [7:0] anaRdata,
   input wire logic anaAck,
   output logic ibPsel,
   output logic ibPenable,
   output logic ibPwrite,
   output logic [15:0] ibPaddr,
   output logic [31:0] ibPwdata,
   output logic [1:0] ibTarget,
   input wire logic [31:0] ibPrdata,
   input wire logic ibPready
);

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [2:0] analogTargetSelect;
   logic analogOffsetAutostep;
   logic analogDirectionRead;
   logic [7:0] analogIndirectData;
   logic [1:0] internalBusTarget;
   logic internalBusAutostep;
   logic internalBusReadStart;
   logic internalBusEnable;
   logic [7:0] internalBusAddrLow;
   logic [7:0] internalBusAddrHigh;
   logic [7:0] internalBusDataByte [4];
   logic ibBusy;
   logic ibIsRead;
   logic ibStart;
   logic ibWrite;

   irb_req_if reqBus ();

   irb_apb_master engine (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .req(reqBus),
      .ibPsel(ibPsel),
      .ibPenable(ibPenable),
      .ibPwrite(ibPwrite),
      .ibPaddr(ibPaddr),
      .ibPwdata(ibPwdata),
      .ibTarget(ibTarget),
      .ibPrdata(ibPrdata),
      .ibPready(ibPready)
   );

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire [7:0] regIdx = paddr[ADDR_W-1:2];
   wire hitAnaCtrl = (regIdx == IDX_ANA_CTRL);
   wire hitAnaOffset = (regIdx == IDX_ANA_OFFSET);
   wire hitAnaData = (regIdx == IDX_ANA_DATA);
   wire hitIbCtrl = (regIdx == IDX_IB_CTRL);
   wire hitIbAddrLow = (regIdx == IDX_IB_ADDR_LOW);
   wire hitIbAddrHigh = (regIdx == IDX_IB_ADDR_HIGH);
   wire hitIbData = (regIdx >= IDX_IB_DATA0) && (regIdx <= IDX_IB_DATA3);
   wire [1:0] dataLane = 2'(regIdx - IDX_IB_DATA0);
   wire mapped = hitAnaCtrl | hitAnaOffset | hitAnaData | hitIbCtrl |
                 hitIbAddrLow | hitIbAddrHigh | hitIbData;

   wire accessPhase = psel & penable & ~pready;
   wire doneEdge = psel & penable & pready;
   // writes land only on the completing edge, low lane only
   wire wrEdge = doneEdge & pwrite & pstrb[0] & mapped;

   // ---------------------------------------------------------------
   // analog path decode
   // ---------------------------------------------------------------
   wire anaIsRx = (analogTargetSelect == ANA_SEL_RX);
   wire anaIsTx = (analogTargetSelect == ANA_SEL_TX);
   // reserved codes behave like the disabled code
   wire anaTargetOk = anaIsRx | anaIsTx;
   // a data access goes out only in the programmed direction
   wire anaDirMatch = pwrite ? (pstrb[0] & ~analogDirectionRead)
                             : analogDirectionRead;
   wire needAna = hitAnaData & anaTargetOk & anaDirMatch;
   wire anaLaunch = accessPhase & needAna & ~anaReq & ~anaAck;
   wire anaStepEn = anaAck & analogOffsetAutostep;

   // ---------------------------------------------------------------
   // internal bus path decode
   // ---------------------------------------------------------------
   wire [15:0] ibAddr = {internalBusAddrHigh, internalBusAddrLow};
   wire ibWritable = (internalBusTarget == IB_TGT_RX) |
                     (internalBusTarget == IB_TGT_EDID);
   wire [15:0] ibStep = (internalBusTarget == IB_TGT_RX) ?
                        IB_STEP_WORD : IB_STEP_BYTE;
   wire ibDone = reqBus.done;
   wire ibRdKick = wrEdge & hitIbCtrl & pwdata[IB_RD_BIT] &
                   pwdata[IB_EN_BIT] & ~ibBusy;
   // writing the top byte sends the assembled word
   wire ibWrKick = wrEdge & hitIbData & (dataLane == 2'h3) &
                   internalBusEnable & ibWritable & ~ibBusy;
   // address and data bytes are frozen while a transfer runs
   wire ibRegWrOk = wrEdge & ~ibBusy;

   assign reqBus.start = ibStart;
   assign reqBus.write = ibWrite;
   assign reqBus.target = internalBusTarget;
   assign reqBus.addr = ibAddr;
   assign reqBus.wdata = {internalBusDataByte[3], internalBusDataByte[2],
                          internalBusDataByte[1], internalBusDataByte[0]};

   // ---------------------------------------------------------------
   // read data mux
   // ---------------------------------------------------------------
   wire [7:0] anaCtrlByte = {3'h0, analogTargetSelect,
                             analogOffsetAutostep, analogDirectionRead};
   wire [7:0] ibCtrlByte = {3'h0, internalBusTarget, internalBusAutostep,
                            internalBusReadStart, internalBusEnable};
   wire [7:0] readByte =
      hitAnaCtrl ? anaCtrlByte :
      hitAnaOffset ? anaOffset :
      hitAnaData ? analogIndirectData :
      hitIbCtrl ? ibCtrlByte :
      hitIbAddrLow ? internalBusAddrLow :
      hitIbAddrHigh ? internalBusAddrHigh :
      hitIbData ? internalBusDataByte[dataLane] : RST_BYTE;
   wire [7:0] answerByte = needAna ? anaRdata : readByte;

   // ---------------------------------------------------------------
   // apb slave answer
   // ---------------------------------------------------------------
   // analog data accesses that go out wait for the far side, all others take one wait
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= RST_WORD;
      end else begin
         pready <= accessPhase & (~needAna | anaAck);
         if (accessPhase & (~needAna | anaAck)) begin
            pslverr <= ~mapped;
            prdata <= pwrite ? RST_WORD : {24'h000000, answerByte};
         end
      end
   end

   // ---------------------------------------------------------------
   // analog control and offset
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         analogTargetSelect <= RST_SEL3;
         analogOffsetAutostep <= 1'b0;
         analogDirectionRead <= 1'b0;
      end else if (wrEdge & hitAnaCtrl) begin
         analogTargetSelect <= pwdata[ANA_SEL_MSB:ANA_SEL_LSB];
         analogOffsetAutostep <= pwdata[ANA_STEP_BIT];
         analogDirectionRead <= pwdata[ANA_DIR_BIT];
      end
   end

   // offset output is the register itself
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         anaOffset <= RST_BYTE;
      end else if (wrEdge & hitAnaOffset) begin
         anaOffset <= pwdata[7:0];
      end else if (anaStepEn) begin
         anaOffset <= anaOffset + ANA_STEP;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         analogIndirectData <= RST_BYTE;
      end else if (anaAck & ~anaWrite) begin
         analogIndirectData <= anaRdata;
      end else if (wrEdge & hitAnaData & anaTargetOk) begin
         analogIndirectData <= pwdata[7:0];
      end
   end

   // ---------------------------------------------------------------
   // analog request, held until the far side acknowledges
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         anaReq <= 1'b0;
         anaWrite <= 1'b0;
         anaSelRx <= 1'b0;
         anaSelTx <= 1'b0;
         anaWdata <= RST_BYTE;
      end else if (anaLaunch) begin
         anaReq <= 1'b1;
         anaWrite <= pwrite;
         anaSelRx <= anaIsRx;
         anaSelTx <= anaIsTx;
         anaWdata <= pwdata[7:0];
      end else if (anaAck) begin
         anaReq <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // internal bus control
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         internalBusTarget <= RST_SEL2;
         internalBusAutostep <= 1'b0;
         internalBusEnable <= 1'b0;
      end else if (wrEdge & hitIbCtrl) begin
         internalBusTarget <= pwdata[IB_SEL_MSB:IB_SEL_LSB];
         internalBusAutostep <= pwdata[IB_STEP_BIT];
         internalBusEnable <= pwdata[IB_EN_BIT];
      end
   end

   // set by a kick, cleared by the read completion
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         internalBusReadStart <= 1'b0;
      end else if (ibRdKick) begin
         internalBusReadStart <= 1'b1;
      end else if (ibDone & ibIsRead) begin
         internalBusReadStart <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ibStart <= 1'b0;
         ibWrite <= 1'b0;
         ibBusy <= 1'b0;
         ibIsRead <= 1'b0;
      end else begin
         ibStart <= ibRdKick | ibWrKick;
         if (ibRdKick | ibWrKick) begin
            ibWrite <= ibWrKick;
            ibIsRead <= ibRdKick;
            ibBusy <= 1'b1;
         end else if (ibDone) begin
            ibBusy <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // internal bus address
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         internalBusAddrLow <= RST_BYTE;
         internalBusAddrHigh <= RST_BYTE;
      end else if (ibDone & internalBusAutostep) begin
         {internalBusAddrHigh, internalBusAddrLow} <= ibAddr + ibStep;
      end else if (ibRegWrOk & hitIbAddrLow) begin
         internalBusAddrLow <= pwdata[7:0];
      end else if (ibRegWrOk & hitIbAddrHigh) begin
         internalBusAddrHigh <= pwdata[7:0];
      end
   end

   // ---------------------------------------------------------------
   // internal bus data bytes, lane 0 least significant
   // ---------------------------------------------------------------
   for (genvar i = 0; i < 4; i++) begin : g_data
      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            internalBusDataByte[i] <= RST_BYTE;
         end else if (ibDone & ibIsRead) begin
            internalBusDataByte[i] <= reqBus.rdata[8*i +: 8];
         end else if (ibRegWrOk & hitIbData & (dataLane == 2'(i))) begin
            internalBusDataByte[i] <= pwdata[7:0];
         end
      end
   end

endmodule

// >>> sim/irb_bridge_props.sv
// checker on the bridge ports
`timescale 1ns/10ps
module irb_bridge_props
   import irb_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic anaReq,
   input wire logic anaWrite,
   input wire logic anaSelRx,
   input wire logic anaSelTx,
   input wire logic [7:0] anaOffset,
   input wire logic [7:0] anaWdata,
   input wire logic anaAck,
   input wire logic ibPsel,
   input wire logic ibPenable,
   input wire logic ibPwrite,
   input wire logic [15:0] ibPaddr,
   input wire logic [1:0] ibTarget,
   input wire logic ibPready
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("pready too long");
   property p_read_byte;
      pready && !pwrite |-> prdata[31:8] == 24'h0
         && (!pslverr || prdata[7:0] == 8'h00);
   endproperty
   a_read_byte: assert property (p_read_byte)
      else $error("read data width");
   property p_ana_launch;
      $rose(anaReq) |-> $past(psel && penable && paddr[9:2] == IDX_ANA_DATA)
         && anaWrite == $past(pwrite)
         && (!anaWrite || anaWdata == $past(pwdata[7:0]));
   endproperty
   a_ana_launch: assert property (p_ana_launch)
      else $error("analog launch");
   property p_ana_sel;
      anaReq |-> anaSelRx != anaSelTx;
   endproperty
   a_ana_sel: assert property (p_ana_sel)
      else $error("analog target");
   property p_ana_hold;
      anaReq && !anaAck |=> anaReq && $stable(anaOffset) && $stable(anaWrite);
   endproperty
   a_ana_hold: assert property (p_ana_hold)
      else $error("analog hold");
   property p_ana_end;
      anaReq && anaAck |=> !anaReq && pready;
   endproperty
   a_ana_end: assert property (p_ana_end)
      else $error("analog end");
   property p_ib_ro;
      ibPsel && ibPwrite |-> !ibTarget[1];
   endproperty
   a_ib_ro: assert property (p_ib_ro)
      else $error("read-only write");
   property p_ib_hold;
      ibPsel && !ibPready |=> ibPsel && $stable(ibPaddr) && $stable(ibTarget);
   endproperty
   a_ib_hold: assert property (p_ib_hold)
      else $error("bus hold");
   property p_ib_phase;
      ibPsel && !ibPenable |=> ibPsel ##0 ibPenable;
   endproperty
   a_ib_phase: assert property (p_ib_phase)
      else $error("bus phase");
endmodule

// >>> sim/irb_far_model.sv
// far side model: analog registers and bus slaves
`timescale 1ns/10ps
module irb_far_model (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic slow,
   input wire logic anaReq,
   input wire logic anaWrite,
   input wire logic anaSelTx,
   input wire logic [7:0] anaOffset,
   input wire logic [7:0] anaWdata,
   output logic [7:0] anaRdata,
   output logic anaAck,
   input wire logic ibPsel,
   input wire logic ibPenable,
   input wire logic ibPwrite,
   input wire logic [15:0] ibPaddr,
   input wire logic [31:0] ibPwdata,
   input wire logic [1:0] ibTarget,
   output logic [31:0] ibPrdata,
   output logic ibPready
);
   logic [7:0] anaMem [0:511];
   logic [31:0] ibMem [0:255];
   logic [1:0] anaWait, ibWait;
   wire [8:0] anaIdx = {anaSelTx, anaOffset};
   wire [7:0] ibIdx = {ibTarget, ibPaddr[5:0]};
   initial begin
      for (int i = 0; i < 256; i++) begin
         ibMem[i] = ~{24'h0, i[7:0]};
      end
   end
   // data lines toggle outside the answer cycle so stale values never match
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         anaAck <= 1'b0;
         anaWait <= 2'h0;
         anaRdata <= 8'h00;
      end else if (anaReq && !anaAck && anaWait >= {slow, slow}) begin
         anaAck <= 1'b1;
         anaWait <= 2'h0;
         anaRdata <= anaMem[anaIdx];
         if (anaWrite) begin
            anaMem[anaIdx] <= anaWdata;
         end
      end else begin
         anaAck <= 1'b0;
         anaWait <= anaReq ? anaWait + 2'h1 : 2'h0;
         anaRdata <= ~anaRdata;
      end
   end
   // plain always: the table is also loaded by the initial block
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ibPready <= 1'b0;
         ibWait <= 2'h0;
         ibPrdata <= 32'h0;
      end else if (ibPsel && ibPenable && !ibPready && ibWait >= {slow, slow})
      begin
         ibPready <= 1'b1;
         ibWait <= 2'h0;
         ibPrdata <= ibMem[ibIdx];
         if (ibPwrite) begin
            ibMem[ibIdx] <= ibPwdata;
         end
      end else begin
         ibPready <= 1'b0;
         ibWait <= ibPenable ? ibWait + 2'h1 : 2'h0;
         ibPrdata <= ~ibPrdata;
      end
   end
endmodule

// >>> sim/irb_bridge_bench.sv
// self-checking bench for the bridge
`timescale 1ns/10ps
module irb_bridge_bench;
   import irb_pkg::*;
   logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, slow, err;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic anaReq, anaWrite, anaSelRx, anaSelTx, anaAck;
   logic [7:0] anaOffset, anaWdata, anaRdata, rd;
   logic ibPsel, ibPenable, ibPwrite, ibPready;
   logic [15:0] ibPaddr, lastAddr;
   logic [31:0] ibPwdata, ibPrdata;
   logic [1:0] ibTarget, lastTgt;
   int mismatches = 0, nChecks = 0, ibCount = 0, snap;
   logic [7:0] regs [10] = '{IDX_ANA_CTRL, IDX_ANA_OFFSET, IDX_ANA_DATA,
      IDX_IB_CTRL, IDX_IB_ADDR_LOW, IDX_IB_ADDR_HIGH, IDX_IB_DATA0,
      IDX_IB_DATA1, IDX_IB_DATA2, IDX_IB_DATA3};
   logic [7:0] word [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
   logic [2:0] badSel [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

   irb_bridge u_irb_bridge (.core_clk(core_clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .anaReq(anaReq), .anaWrite(anaWrite),
      .anaSelRx(anaSelRx), .anaSelTx(anaSelTx), .anaOffset(anaOffset),
      .anaWdata(anaWdata), .anaRdata(anaRdata), .anaAck(anaAck),
      .ibPsel(ibPsel), .ibPenable(ibPenable), .ibPwrite(ibPwrite),
      .ibPaddr(ibPaddr), .ibPwdata(ibPwdata), .ibTarget(ibTarget),
      .ibPrdata(ibPrdata), .ibPready(ibPready));
   irb_far_model u_irb_far_model (.core_clk(core_clk), .reset_n(reset_n),
      .slow(slow), .anaReq(anaReq), .anaWrite(anaWrite),
      .anaSelTx(anaSelTx), .anaOffset(anaOffset), .anaWdata(anaWdata),
      .anaRdata(anaRdata), .anaAck(anaAck), .ibPsel(ibPsel),
      .ibPenable(ibPenable), .ibPwrite(ibPwrite), .ibPaddr(ibPaddr),
      .ibPwdata(ibPwdata), .ibTarget(ibTarget), .ibPrdata(ibPrdata),
      .ibPready(ibPready));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (ibPsel && !ibPenable) begin
         ibCount <= ibCount + 1;
         lastAddr <= ibPaddr;
         lastTgt <= ibTarget;
      end
   end

   task automatic summarize;
      if (mismatches == 0 && nChecks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, exp);
      nChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // one idle cycle before each setup keeps psel from being driven twice
   task automatic apb(input logic wr, input logic [7:0] idx, wd);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 200);
      if (n >= 200) begin
         mismatches++;
         summarize();
      end
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, wd);
      apb(1'b1, idx, wd);
   endtask
   task automatic rc(input logic [7:0] idx, exp, input string what);
      apb(1'b0, idx, 8'h00);
      chk(what, {24'h0, rd}, {24'h0, exp});
   endtask
   task automatic poll(input logic [7:0] idx, mask, exp);
      int n;
      n = 0;
      do begin
         apb(1'b0, idx, 8'h00);
         n++;
      end while ((rd & mask) !== exp && n < 50);
      if (n >= 50) begin
         mismatches++;
         summarize();
      end
   endtask

   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hf;
      slow = 1'b0;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      foreach (regs[i]) rc(regs[i], 8'h00, "reset");
      apb(1'b0, 8'h43, 8'h00);
      chk("slverr", {31'h0, err}, 32'h1);
      wr(IDX_ANA_CTRL, 8'h12);
      wr(IDX_ANA_OFFSET, 8'h05);
      wr(IDX_ANA_DATA, 8'ha5);
      wr(IDX_ANA_DATA, 8'h3c);
      rc(IDX_ANA_OFFSET, 8'h07, "step");
      wr(IDX_ANA_CTRL, 8'h14);
      wr(IDX_ANA_OFFSET, 8'h05);
      wr(IDX_ANA_DATA, 8'h77);
      foreach (badSel[i]) begin
         wr(IDX_ANA_CTRL, {3'h0, badSel[i], 2'h0});
         wr(IDX_ANA_DATA, 8'h99);
      end
      rc(IDX_ANA_OFFSET, 8'h05, "hold");
      slow <= 1'b1;
      wr(IDX_ANA_CTRL, 8'h13);
      rc(IDX_ANA_DATA, 8'ha5, "rx");
      rc(IDX_ANA_DATA, 8'h3c, "rx next");
      wr(IDX_ANA_CTRL, 8'h15);
      wr(IDX_ANA_OFFSET, 8'h05);
      rc(IDX_ANA_DATA, 8'h77, "tx");
      wr(IDX_IB_CTRL, 8'h05);
      wr(IDX_IB_ADDR_LOW, 8'h10);
      wr(IDX_IB_ADDR_HIGH, 8'h02);
      foreach (word[i]) wr(IDX_IB_DATA0 + 8'(i), word[i]);
      poll(IDX_IB_ADDR_LOW, 8'hff, 8'h14);
      wr(IDX_IB_ADDR_LOW, 8'h10);
      wr(IDX_IB_CTRL, 8'h07);
      poll(IDX_IB_CTRL, 8'h02, 8'h00);
      chk("addr", {16'h0, lastAddr}, 32'h210);
      foreach (word[i]) rc(IDX_IB_DATA0 + 8'(i), word[i], "byte");
      wr(IDX_IB_CTRL, 8'h0d);
      wr(IDX_IB_ADDR_LOW, 8'h20);
      wr(IDX_IB_ADDR_HIGH, 8'h00);
      wr(IDX_IB_DATA3, 8'h44);
      poll(IDX_IB_ADDR_LOW, 8'hff, 8'h21);
      chk("target", {30'h0, lastTgt}, {30'h0, IB_TGT_EDID});
      for (int t = 2; t < 4; t++) begin
         wr(IDX_IB_CTRL, {3'h0, 2'(t), 3'h5});
         wr(IDX_IB_ADDR_LOW, 8'h20);
         snap = ibCount;
         wr(IDX_IB_DATA3, 8'h55);
         rc(IDX_IB_ADDR_LOW, 8'h20, "ro addr");
         chk("ro launch", ibCount, snap);
         wr(IDX_IB_CTRL, {3'h0, 2'(t), 3'h7});
         poll(IDX_IB_CTRL, 8'h02, 8'h00);
         rc(IDX_IB_DATA0, ~{2'(t), 6'h20}, "ro byte");
         rc(IDX_IB_DATA3, 8'hff, "ro top");
      end
      snap = ibCount;
      wr(IDX_IB_CTRL, 8'h02);
      rc(IDX_IB_CTRL, 8'h00, "off kick");
      wr(IDX_IB_DATA3, 8'h66);
      rc(IDX_IB_DATA1, 8'hff, "off byte");
      rc(IDX_IB_DATA3, 8'h66, "off top");
      chk("off launch", ibCount, snap);
      summarize();
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      mismatches++;
      summarize();
   end
endmodule

bind irb_bridge irb_bridge_props u_irb_bridge_props (.core_clk(core_clk),
   .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .anaReq(anaReq), .anaWrite(anaWrite),
   .anaSelRx(anaSelRx), .anaSelTx(anaSelTx), .anaOffset(anaOffset),
   .anaWdata(anaWdata), .anaAck(anaAck), .ibPsel(ibPsel),
   .ibPenable(ibPenable), .ibPwrite(ibPwrite), .ibPaddr(ibPaddr),
   .ibTarget(ibTarget), .ibPready(ibPready));
